// ===== rtl/srcr_params.svh
// Purpose: Constants for the suspend/resume clock and refresh block
// Assumes: mclk at 20 MHz
// Notes:   Times are in ns; cycle counts derive from them
`ifndef SRCR_PARAMS_SVH
`define SRCR_PARAMS_SVH

// ---------------------------------------------------------------
// Clock
// ---------------------------------------------------------------
`define SRCR_MCLK_HZ        20000000
`define SRCR_MAIN_XTAL_KHZ  14318
`define SRCR_RTC_XTAL_HZ    32768

// ---------------------------------------------------------------
// Select codes
// ---------------------------------------------------------------
`define SRCR_CODE_W         5
`define SRCR_CODE_ENTER     5'h15
`define SRCR_CODE_EXIT      5'h16

// ---------------------------------------------------------------
// Refresh timing
// ---------------------------------------------------------------
`define SRCR_REF_PERIOD_NS  15260
`define SRCR_REF_PULSE_NS   1000
`define SRCR_REF_TOL_NS     500
`define SRCR_CNT_W          9
`define SRCR_REF_PERIOD_CYC ((`SRCR_REF_PERIOD_NS * (`SRCR_MCLK_HZ / 1000000)) / 1000)
`define SRCR_REF_PULSE_CYC  ((`SRCR_REF_PULSE_NS * (`SRCR_MCLK_HZ / 1000000)) / 1000)

`endif

// ===== rtl/srcr_pkg.sv
// Purpose: Types for the suspend/resume clock and refresh block
// Assumes: srcr_params.svh included
// Notes:   State of each module is one packed struct
`include "srcr_params.svh"

package srcr_pkg;

  typedef enum logic [0:0] {
    SRCR_RUN     = 1'b0,
    SRCR_SUSPEND = 1'b1
  } srcr_mode_t;

  typedef struct packed {
    srcr_mode_t              mode;
    logic                    clk_prev;
    logic [`SRCR_CNT_W-1:0]  cnt;
    logic                    refresh;
  } srcr_state_t;

endpackage

// ===== rtl/srcr_sync.sv
// Purpose: Three-flop synchroniser with agreement filter
// Assumes: Inputs asynchronous to mclk
// Notes:   Output follows once second and third stages agree
`timescale 1ns/1ps

module srcr_sync #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } srcr_sync_t;

  srcr_sync_t st_r;
  srcr_sync_t st_nxt;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.q[i] = st_r.s3[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule

// ===== rtl/srcr_top.sv
// Purpose: Host clock source switch, suspend decode and DRAM refresh pulse
// Assumes: mclk 20 MHz; crystal and select inputs are asynchronous pins
// Notes:   Host clock is a mux of the raw main crystal and the synchronised RTC crystal
`timescale 1ns/1ps
`include "srcr_params.svh"

// Operation
// - Outside suspend, host clock output follows the 14.318 MHz main crystal.
// - In suspend, host clock output follows the 32.768 kHz RTC crystal.
// - Code 15H on the select code lines enters suspend.
// - Code 16H on the select code lines leaves suspend.
// - In suspend, one 1.0 us refresh pulse every 15.26 us; the code's 305 mclk period gives 15.25 us.
// - RTC time base is the 32.768 kHz crystal, also the slow clock.
// - Entry needs qualifier low, write strobe low, host clock falling edge.
// - Exit on 16H is taken on a host clock falling edge.
// - Decode only with qualifier low and DMA disable input low.
module srcr_top
  import srcr_pkg::*;
(
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire logic                   main_crystal,
  input  wire logic                   rtc_crystal,
  input  wire logic [`SRCR_CODE_W-1:0] select_code_lines,
  input  wire logic                   select_code_qualifier_n,
  input  wire logic                   io_write_n,
  input  wire logic                   dma_ack_decode_disable,
  output logic                        host_clock_out,
  output logic                        suspend_refresh_pulse,
  output logic                        suspend_active
);

  localparam int                     SYNC_W  = `SRCR_CODE_W + 5;
  localparam logic [`SRCR_CNT_W-1:0] PER_MAX = `SRCR_CNT_W'(`SRCR_REF_PERIOD_CYC - 1);
  localparam logic [`SRCR_CNT_W-1:0] PUL_CYC = `SRCR_CNT_W'(`SRCR_REF_PULSE_CYC);

  srcr_state_t               st_r;
  srcr_state_t               st_nxt;
  logic [SYNC_W-1:0]         sync_q;
  logic [`SRCR_CODE_W-1:0]   code_s;
  logic                      qual_s;
  logic                      iow_s;
  logic                      dack_s;
  logic                      rtc_s;
  logic                      main_s;
  logic                      clk_mon;
  logic                      clk_fall;
  logic                      decode_en;
  logic                      enter_hit;
  logic                      exit_hit;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Active-low pins enter inverted so a cleared synchroniser reads inactive
  srcr_sync #(
    .W (SYNC_W)
  ) u_sync (
    .mclk  (mclk),
    .reset (reset),
    .d     ({select_code_lines, ~select_code_qualifier_n, ~io_write_n,
              dma_ack_decode_disable, rtc_crystal, main_crystal}),
    .q     (sync_q)
  );

  assign code_s   = sync_q[SYNC_W-1 -: `SRCR_CODE_W];
  assign qual_s   = sync_q[4];
  assign iow_s    = sync_q[3];
  assign dack_s   = sync_q[2];
  assign rtc_s    = sync_q[1];
  assign main_s   = sync_q[0];

  // ---------------------------------------------------------------
  // Decode qualification
  // ---------------------------------------------------------------
  assign clk_mon   = (st_r.mode == SRCR_SUSPEND) ? rtc_s : main_s;
  assign clk_fall  = st_r.clk_prev & ~clk_mon;
  assign decode_en = qual_s & ~dack_s;
  assign enter_hit = decode_en & clk_fall & iow_s & (code_s == `SRCR_CODE_ENTER);
  assign exit_hit  = decode_en & clk_fall & (code_s == `SRCR_CODE_EXIT);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt          = st_r;
    st_nxt.clk_prev = clk_mon;
    case (st_r.mode)
      SRCR_RUN: begin
        st_nxt.cnt     = '0;
        st_nxt.refresh = 1'b0;
        if (enter_hit) begin
          st_nxt.mode     = SRCR_SUSPEND;
          st_nxt.clk_prev = rtc_s;
          st_nxt.refresh  = 1'b1;
        end
      end
      SRCR_SUSPEND: begin
        if (st_r.cnt == PER_MAX) begin
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + `SRCR_CNT_W'(1);
        end
        st_nxt.refresh = (st_nxt.cnt < PUL_CYC);
        if (exit_hit) begin
          st_nxt.mode     = SRCR_RUN;
          st_nxt.clk_prev = main_s;
          st_nxt.cnt      = '0;
          st_nxt.refresh  = 1'b0;
        end
      end
      default: begin
        st_nxt = '0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // Slow source is the synchronised RTC crystal, fast is the raw crystal
  assign host_clock_out        = (st_r.mode == SRCR_SUSPEND) ? rtc_s : main_crystal;
  assign suspend_refresh_pulse = st_r.refresh;
  assign suspend_active        = (st_r.mode == SRCR_SUSPEND);

endmodule

// ===== verif/srcr_monitor.sv
// Purpose: Port assertions for srcr_top
// Assumes: Pin to mode change is 5 mclk through the synchroniser
// Notes:   Refresh pulse 20 mclk
`timescale 1ns/1ps
module srcr_monitor (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       main_crystal,
  input wire logic       rtc_crystal,
  input wire logic [4:0] select_code_lines,
  input wire logic       select_code_qualifier_n,
  input wire logic       io_write_n,
  input wire logic       dma_ack_decode_disable,
  input wire logic       host_clock_out,
  input wire logic       suspend_refresh_pulse,
  input wire logic       suspend_active
);
  // ------
  // Checks
  // ------
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  run_clk_a: assert property (
    !suspend_active |-> host_clock_out == main_crystal) else $error("run clock");
  idle_ref_a: assert property (
    !suspend_active && !$past(suspend_active) |-> !suspend_refresh_pulse) else $error("idle");
  entry_ref_a: assert property (
    $rose(suspend_active) |-> suspend_refresh_pulse) else $error("entry pulse");
  ref_gap_a: assert property (
    $fell(suspend_refresh_pulse) |=> !suspend_refresh_pulse[*8]) else $error("gap");
  enter_a: assert property (
    $rose(suspend_active) |-> $past(select_code_lines, 5) == 5'h15) else $error("enter");
  enter_qual_a: assert property (
    $rose(suspend_active) |-> !$past(select_code_qualifier_n, 5) && !$past(io_write_n, 5)
      && !$past(dma_ack_decode_disable, 5)) else $error("qualifier");
  leave_a: assert property (
    $fell(suspend_active) |-> $past(select_code_lines, 5) == 5'h16) else $error("leave");
  susp_clk_a: assert property (
    suspend_active && $past(suspend_active, 8) && $changed(host_clock_out)
      |-> host_clock_out == rtc_crystal) else $error("suspend clock");
endmodule
bind srcr_top srcr_monitor mon (
  .mclk                    (mclk),
  .reset                   (reset),
  .main_crystal            (main_crystal),
  .rtc_crystal             (rtc_crystal),
  .select_code_lines       (select_code_lines),
  .select_code_qualifier_n (select_code_qualifier_n),
  .io_write_n              (io_write_n),
  .dma_ack_decode_disable  (dma_ack_decode_disable),
  .host_clock_out          (host_clock_out),
  .suspend_refresh_pulse   (suspend_refresh_pulse),
  .suspend_active          (suspend_active)
);

// ===== verif/srcr_osc_model.sv
// Purpose: Board crystals feeding srcr_top
// Assumes: Both run free
// Notes:   Offset avoids mclk edges
`timescale 1ns/1ps
module srcr_osc_model (
  output logic main_crystal,
  output logic rtc_crystal
);
  // -----------
  // Oscillators
  // -----------
  initial begin
    main_crystal = 1'b0;
    #3.7;
    forever #34.92 main_crystal = ~main_crystal;
  end
  initial begin
    rtc_crystal = 1'b0;
    forever #15258.79 rtc_crystal = ~rtc_crystal;
  end
endmodule

// ===== verif/tb_top.sv
// Purpose: Directed bench for srcr_top
// Assumes: Crystals from srcr_osc_model
// Notes:   Drive word is qualifier, write, disable, code
`timescale 1ns/1ps
module tb_top;
  logic [4:0] select_code_lines;
  logic       mclk, reset, main_crystal, rtc_crystal, host_clock_out, suspend_active;
  logic       select_code_qualifier_n, io_write_n, dma_ack_decode_disable, suspend_refresh_pulse;
  int         n_errors, comparisons, cyc, w, p;
  // -----
  // Tasks
  // -----
  srcr_top uut (
    .mclk                    (mclk),
    .reset                   (reset),
    .main_crystal            (main_crystal),
    .rtc_crystal             (rtc_crystal),
    .select_code_lines       (select_code_lines),
    .select_code_qualifier_n (select_code_qualifier_n),
    .io_write_n              (io_write_n),
    .dma_ack_decode_disable  (dma_ack_decode_disable),
    .host_clock_out          (host_clock_out),
    .suspend_refresh_pulse   (suspend_refresh_pulse),
    .suspend_active          (suspend_active)
  );
  srcr_osc_model osc (
    .main_crystal (main_crystal),
    .rtc_crystal  (rtc_crystal)
  );
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 9000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic close_out;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic drive(input logic [7:0] v);
    @(posedge mclk);
    select_code_lines <= v[4:0];
    select_code_qualifier_n <= v[7];
    io_write_n <= v[6];
    dma_ack_decode_disable <= v[5];
  endtask
  task automatic wait_act(input logic v, input int n);
    while (suspend_active !== v && n > 0) begin
      @(negedge mclk);
      n--;
    end
  endtask
  task automatic run_clk_check;
    realtime t0;
    @(posedge host_clock_out);
    t0 = $realtime;
    @(posedge host_clock_out);
    chk(10'(int'($realtime - t0)), 10'h046);
  endtask
  task automatic test_refuse;
    drive(8'h95);
    repeat (60) @(negedge mclk);
    chk({9'h000, suspend_active}, 10'h000);
    drive(8'h55);
    repeat (60) @(negedge mclk);
    chk({9'h000, suspend_active}, 10'h000);
    drive(8'h35);
    repeat (60) @(negedge mclk);
    chk({9'h000, suspend_active}, 10'h000);
    drive(8'h16);
    repeat (60) @(negedge mclk);
    chk({9'h000, suspend_active}, 10'h000);
    run_clk_check();
    $display("test refuse done");
  endtask
  task automatic test_enter;
    w = 0;
    drive(8'h15);
    wait_act(1'b1, 100);
    chk({8'h00, suspend_active, suspend_refresh_pulse}, 10'h003);
    while (suspend_refresh_pulse === 1'b1 && w < 400) begin
      w++;
      @(negedge mclk);
    end
    p = w;
    while (suspend_refresh_pulse === 1'b0 && p < 400) begin
      p++;
      @(negedge mclk);
    end
    chk(10'(w), 10'h014);
    chk(10'(p), 10'h131);
    $display("test enter done");
  endtask
  task automatic test_hold;
    drive(8'h36);
    repeat (700) @(negedge mclk);
    chk({9'h000, suspend_active}, 10'h001);
    repeat (2) begin
      @(rtc_crystal);
      repeat (8) @(negedge mclk);
      chk({9'h000, host_clock_out}, {9'h000, rtc_crystal});
    end
    chk({9'h000, suspend_active}, 10'h001);
    $display("test hold done");
  endtask
  task automatic test_exit;
    drive(8'h56);
    wait_act(1'b0, 800);
    repeat (400) @(negedge mclk);
    chk({8'h00, suspend_active, suspend_refresh_pulse}, 10'h000);
    run_clk_check();
    $display("test exit done");
  endtask
  task automatic test_reset;
    drive(8'h15);
    wait_act(1'b1, 100);
    chk({9'h000, suspend_active}, 10'h001);
    drive(8'h80);
    reset <= 1'b1;
    repeat (2) @(negedge mclk);
    chk({8'h00, suspend_active, suspend_refresh_pulse}, 10'h000);
    run_clk_check();
    @(negedge mclk);
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (60) @(negedge mclk);
    chk({8'h00, suspend_active, suspend_refresh_pulse}, 10'h000);
    $display("test reset done");
  endtask
  initial begin
    reset = 1'b1;
    select_code_lines = 5'h00;
    select_code_qualifier_n = 1'b1;
    io_write_n = 1'b1;
    dma_ack_decode_disable = 1'b0;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    repeat (8) @(negedge mclk);
    chk({8'h00, suspend_active, suspend_refresh_pulse}, 10'h000);
    test_refuse();
    test_enter();
    test_hold();
    test_exit();
    test_reset();
    close_out();
  end
endmodule
